// >>> sim/led_seq_chk.sv
// Purpose: Port checks for the LED driver protection sequencer.
// Assumes: Shortened counts are handed on by the bind below.
// Notes:   Helper counters track gate on time, fault age and dim low time.
module led_seq_chk #(
  parameter logic [25:0] RECOVERY_CYCLES = 26'd200,
  parameter logic [25:0] PWM_DIMMING_INPUT_LOW_CYCLES = 26'd30,
  parameter logic [7:0]  LEB_CYCLES      = 8'h03
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        vcc_ovp,
  input wire logic        aux_fast_ovp,
  input wire logic        line_good,
  input wire logic        over_temp,
  input wire logic        cs_peak,
  input wire logic        cv_active,
  input wire logic [7:0]  cv_level,
  input wire logic        analog_dim_enable,
  input wire logic        analog_dim_full,
  input wire logic        pwm_dimming_input,
  input wire logic        pwm_dim_open,
  input wire logic        gate_drive,
  input wire logic [7:0]  output_current_setpoint
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================
  // Helper counters
  logic [7:0]  on_c;   // Cycles since gate on
  logic [25:0] age;    // Cycles since last vcc_ovp or aux_fast_ovp
  logic [25:0] low_c;  // Cycles of dim input held low

  // Age starts saturated so reset alone never blocks the gate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_c  <= 8'h00;
      age   <= RECOVERY_CYCLES;
      low_c <= 26'h0;
    end else begin
      on_c  <= gate_drive ? on_c + 8'h01 : 8'h00;
      low_c <= (!pwm_dimming_input && !pwm_dim_open) ? low_c + 26'h1 : 26'h0;
      if (vcc_ovp || aux_fast_ovp) begin
        age <= 26'h0;
      end else if (age < RECOVERY_CYCLES) begin
        age <= age + 26'h1;
      end
    end
  end

  // ==========================================
  // Assertions
  a_vcc_gate_off: assert property (vcc_ovp |=> !gate_drive)
    else $error("gate on after supply overvoltage");
  a_fast_ovp_off: assert property (aux_fast_ovp |=> !gate_drive)
    else $error("gate on after aux overvoltage");
  a_brownout_off: assert property (!line_good |=> !gate_drive)
    else $error("gate on during brown-out");
  a_peak_ends_gate: assert property (gate_drive && cs_peak
    && on_c >= LEB_CYCLES |=> !gate_drive)
    else $error("gate survived peak limit");
  a_dim_disable: assert property (!analog_dim_enable |=> !gate_drive)
    else $error("gate on with analog dim disabled");
  a_temp_gate_off: assert property (over_temp |=> !gate_drive)
    else $error("gate on while hot");
  a_wait_holds_low: assert property (gate_drive |-> age >= RECOVERY_CYCLES)
    else $error("gate on inside fault wait");
  a_pwm_dimming_input_low_off: assert property (low_c > PWM_DIMMING_INPUT_LOW_CYCLES + 26'd2
    |-> !gate_drive)
    else $error("gate on with dim input held low");
  a_open_full_sp: assert property (
    (pwm_dim_open && analog_dim_full && !cv_active) [*4]
    |=> output_current_setpoint == 8'hff)
    else $error("setpoint not full with dim open");
  a_cv_clamp_sp: assert property ((cv_active && $stable(cv_level)) [*2]
    |=> output_current_setpoint <= cv_level)
    else $error("setpoint above voltage loop limit");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");

  c_gate_rise: cover property ($rose(gate_drive));
  c_vcc_fault: cover property (vcc_ovp ##1 !vcc_ovp);
  c_dim_low: cover property (low_c > PWM_DIMMING_INPUT_LOW_CYCLES);
endmodule : led_seq_chk

bind led_driver_protection_sequencer led_seq_chk #(
  .RECOVERY_CYCLES(RECOVERY_CYCLES), .PWM_DIMMING_INPUT_LOW_CYCLES(PWM_DIMMING_INPUT_LOW_CYCLES), .LEB_CYCLES(LEB_CYCLES)
) chk (.clock, .rst, .rd, .rdata, .vcc_ovp, .aux_fast_ovp, .line_good, .over_temp,
  .cs_peak, .cv_active, .cv_level, .analog_dim_enable, .analog_dim_full,
  .pwm_dimming_input, .pwm_dim_open, .gate_drive, .output_current_setpoint);

// >>> sim/power_stage_model.sv
// Purpose: Flyback power stage seen from the gate and sense pins.
// Assumes: Drain rings one valley every four cycles once the gate is off.
// Notes:   Mode 1 trips the short comparator inside blanking, mode 2 after it.
module power_stage_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       gate_drive,
  input  wire logic [1:0] short_mode,
  output logic            valley_pulse,
  output logic            cs_peak,
  output logic            cs_ref_trip,
  output logic            cs_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] on_c;  // Current ramp length
  logic [1:0] ring;  // Drain ringing phase

  // Ramp and ring follow the gate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_c <= 8'h00;
      ring <= 2'h0;
    end else begin
      on_c <= gate_drive ? on_c + 8'h01 : 8'h00;
      ring <= gate_drive ? 2'h0 : ring + 2'h1;
    end
  end

  // A mode 1 winding short ramps fast and hits the peak limit early
  assign valley_pulse = !gate_drive && ring == 2'h2;
  assign cs_peak      = gate_drive && on_c >= (short_mode == 2'h1 ? 8'h03 : 8'h06);
  assign cs_ref_trip  = gate_drive && on_c >= 8'h05;
  assign cs_stop      = gate_drive && short_mode != 2'h0
                        && on_c >= (short_mode == 2'h1 ? 8'h01 : 8'h03);
endmodule : power_stage_model

// >>> sim/tb_led_driver_protection_sequencer.sv
// Purpose: Self-checking bench for the protection sequencer.
// Assumes: Shortened wait, undervoltage and dim-low counts.
// Notes:   Outputs are copied at the falling edge and judged at the rising edge.
`include "led_seq_regs.svh"
module tb_led_driver_protection_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, wr, rd, vcc_ovp, aux_fast_ovp, aux_slow_ovp, aux_short_low;
  logic line_good, over_temp, half_line, cv_active, vout_below_80, vout_below_85;
  logic analog_dim_enable, analog_dim_full, pwm_dimming_input, pwm_dim_open;
  logic valley_pulse, cs_peak, cs_ref_trip, cs_stop, gate_drive, cv_boost, pgen;
  logic gate_s, bst_s, gp;
  logic [1:0] short_mode;
  logic [7:0] addr, line_sample, line_level, cv_level, analog_dimming_input;
  logic [7:0] peak_ref, output_current_setpoint, sp_s, pr_s;
  logic [31:0] wdata, rdata, rd_s, d;
  int error_cnt, checks_done, cyc, rises, r0, i, h, p, a, pc, s1, s2;

  led_driver_protection_sequencer #(.RECOVERY_CYCLES(26'd200), .UVP_CYCLES(26'd50),
    .PWM_DIMMING_INPUT_LOW_CYCLES(26'd30)) DUT (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .vcc_ovp, .aux_fast_ovp, .aux_slow_ovp, .aux_short_low, .line_good, .over_temp,
    .cs_peak, .cs_ref_trip, .cs_stop, .valley_pulse, .half_line, .line_sample,
    .line_level, .cv_active, .cv_level, .vout_below_80, .vout_below_85,
    .analog_dim_enable, .analog_dim_full, .analog_dimming_input, .pwm_dimming_input,
    .pwm_dim_open, .gate_drive, .peak_ref, .output_current_setpoint, .cv_boost);
  power_stage_model stage (.clock, .rst, .gate_drive, .short_mode, .valley_pulse,
    .cs_peak, .cs_ref_trip, .cs_stop);

  // ==========================================
  // Clock, sampling and background stimulus
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    gate_s <= gate_drive;
    sp_s   <= output_current_setpoint;
    pr_s   <= peak_ref;
    bst_s  <= cv_boost;
    rd_s   <= rdata;
  end
  // Line shape, half-line marks, PWM dim wave, gate pulse count, timeout
  always @(posedge clock) begin
    cyc         <= cyc + 1;
    half_line   <= (cyc % 64) == 63;
    line_sample <= 8'($urandom);
    gp          <= gate_s;
    if (gate_s && !gp) rises <= rises + 1;
    if (pgen) begin
      pc                <= (pc + 1 >= p) ? 0 : pc + 1;
      pwm_dimming_input <= pc < h;
    end
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks_done++;
    if ($isunknown(got) || (got > exp ? got - exp : exp - got) > tol) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dt);
    addr  <= ad;
    wdata <= dt;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ad, output logic [31:0] dt);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(posedge clock);
    dt = rd_s;
  endtask : reg_rd
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clock);
      if (gate_s !== 1'b0) k++;
    end
    cmp(k, 0, 0);
  endtask : quiet
  task automatic comes(input int n);
    int k;
    for (k = 0; k < n && gate_s !== 1'b1; k++) @(posedge clock);
    cmp(gate_s, 1, 0);
  endtask : comes
  function automatic logic [7:0] exp_sp(input int hh, input int pp, input int aa);
    int du;
    du = (hh * 256) / pp;
    if (du >= 243) return 8'(aa);
    return 8'((aa * du) >> 8);
  endfunction : exp_sp
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ==========================================
  // Main sequence
  initial begin
    {wr, rd, vcc_ovp, aux_fast_ovp, aux_slow_ovp, aux_short_low, over_temp} = '0;
    {cv_active, vout_below_80, vout_below_85, short_mode, pgen, half_line} = '0;
    {line_good, analog_dim_enable, pwm_dimming_input, analog_dim_full, pwm_dim_open} = '1;
    {addr, line_sample, wdata, pc, p, h} = '0;
    line_level = 8'h80;
    cv_level = 8'hff;
    analog_dimming_input = 8'hff;
    rst = 1'b1;
    void'($urandom(67183));
    repeat (8) @(posedge clock);
    cmp(gate_drive, 0, 0);
    cmp(output_current_setpoint, 8'hff, 0);
    rst <= 1'b0;
    reg_rd(`CTRL_OFS, d);
    cmp(d, `CTRL_RST, 0);
    reg_wr(8'h0c, $urandom);
    reg_rd(8'h0c, d);
    cmp(d, 0, 0);
    $display("test reset and registers done");
    reg_wr(`CTRL_OFS, 32'h1);
    // Timed faults, each hit again inside its wait
    for (i = 0; i < 3; i++) begin
      comes(400);
      case (i)
        0: vcc_ovp <= 1'b1;
        1: aux_fast_ovp <= 1'b1;
        default: aux_short_low <= 1'b1;
      endcase
      repeat (i == 2 ? 60 : 1) @(posedge clock);
      {vcc_ovp, aux_fast_ovp, aux_short_low} <= '0;
      reg_rd(`STAT_OFS, d);
      cmp(d[4:2], i + 1, 0);
      quiet(100);
      vcc_ovp <= 1'b1;
      @(posedge clock);
      vcc_ovp <= 1'b0;
      quiet(190);
      comes(300);
    end
    $display("test timed faults done");
    // Holds that stop switching, the dim-low hold only after its timer
    for (i = 0; i < 4; i++) begin
      comes(400);
      r0 = rises;
      case (i)
        0: line_good <= 1'b0;
        1: over_temp <= 1'b1;
        2: analog_dim_enable <= 1'b0;
        default: {pwm_dim_open, pwm_dimming_input} <= 2'b00;
      endcase
      repeat (i == 3 ? 20 : 1) @(posedge clock);
      if (i == 3) cmp(rises > r0, 1, 0);
      if (i == 3) repeat (16) @(posedge clock);
      quiet(40);
      {line_good, analog_dim_enable, pwm_dimming_input, pwm_dim_open} <= '1;
      over_temp <= 1'b0;
      comes(100);
    end
    $display("test holds done");
    // PWM duty measurement, near-full duty first
    for (i = 0; i < 5; i++) begin
      p = 30 + $urandom % 11;
      h = (i == 0) ? p - 1 : 12 + $urandom % (p - 20);
      a = (i < 2) ? 255 : 64 + $urandom % 192;
      analog_dim_full <= a == 255;
      analog_dimming_input <= 8'(a);
      pwm_dim_open <= 1'b0;
      pgen <= 1'b1;
      repeat (6 * p) @(posedge clock);
      cmp(sp_s, exp_sp(h, p, a), 3);
    end
    pgen <= 1'b0;
    {pwm_dimming_input, pwm_dim_open, analog_dim_full} <= '1;
    repeat (6) @(posedge clock);
    cmp(sp_s, 8'hff, 0);
    cv_active <= 1'b1;
    cv_level <= 8'h40;
    repeat (4) @(posedge clock);
    cmp(sp_s, 8'h40, 0);
    reg_rd(`SETP_OFS, d);
    cmp(d[7:0], 8'h40, 0);
    // Lower setpoint: later valley, peak reference average falls
    s1 = 0;
    repeat (256) begin
      @(posedge clock);
      s1 += pr_s;
    end
    r0 = rises;
    repeat (5120) @(posedge clock);
    cmp(rises - r0 < 400, 1, 0);
    s2 = 0;
    repeat (256) begin
      @(posedge clock);
      s2 += pr_s;
    end
    cmp(s2 < s1, 1, 0);
    cv_active <= 1'b0;
    $display("test dimming done");
    // Boost threshold chosen by the control register
    reg_wr(`CTRL_OFS, 32'h2);
    vout_below_85 <= 1'b1;
    repeat (3) @(posedge clock);
    cmp(bst_s, 1, 0);
    reg_wr(`CTRL_OFS, 32'h0);
    repeat (3) @(posedge clock);
    cmp(bst_s, 0, 0);
    {vout_below_80, vout_below_85} <= 2'b10;
    repeat (3) @(posedge clock);
    cmp(bst_s, 1, 0);
    vout_below_80 <= 1'b0;
    $display("test boost done");
    // Winding short inside blanking, then outside it
    line_good <= 1'b0;
    repeat (3) @(posedge clock);
    short_mode <= 2'h1;
    r0 = rises;
    line_good <= 1'b1;
    repeat (200) @(posedge clock);
    cmp(rises - r0, 4, 0);
    reg_rd(`STAT_OFS, d);
    cmp(d[4:2], 4, 0);
    short_mode <= 2'h2;
    comes(300);
    r0 = rises;
    repeat (100) @(posedge clock);
    cmp(rises - r0 > 4, 1, 0);
    $display("test winding short done");
    give_verdict();
  end
endmodule : tb_led_driver_protection_sequencer

// >>> verilog/led_driver_protection_sequencer.sv
// Purpose: Gate sequencing, protection timing and setpoint for a
//          quasi-resonant flyback LED controller.
// Assumes: All flag inputs are clean and synchronous to clock.
// Notes:   Analog comparators sit outside; peak_ref feeds a DAC.
`include "led_seq_regs.svh"

module led_driver_protection_sequencer
  import led_seq_pkg::*;
#(
  parameter logic [25:0] RECOVERY_CYCLES = 26'(`RECOVERY_CYC),
  parameter logic [25:0] UVP_CYCLES      = 26'(`UVP_CYC),
  parameter logic [25:0] PWM_DIMMING_INPUT_LOW_CYCLES = 26'(`PWM_DIMMING_INPUT_LOW_CYC),
  parameter logic [7:0]  LEB_CYCLES      = 8'h03,
  parameter logic [7:0]  BCS_CYCLES      = 8'h01,
  parameter logic [7:0]  MAX_ON_CYCLES   = 8'hc8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Comparator flags and samples
  input  wire logic        vcc_ovp,
  input  wire logic        aux_fast_ovp,
  input  wire logic        aux_slow_ovp,
  input  wire logic        aux_short_low,
  input  wire logic        line_good,
  input  wire logic        over_temp,
  input  wire logic        cs_peak,
  input  wire logic        cs_ref_trip,
  input  wire logic        cs_stop,
  input  wire logic        valley_pulse,
  input  wire logic        half_line,
  input  wire logic [7:0]  line_sample,
  input  wire logic [7:0]  line_level,
  input  wire logic        cv_active,
  input  wire logic [7:0]  cv_level,
  input  wire logic        vout_below_80,
  input  wire logic        vout_below_85,
  input  wire logic        analog_dim_enable,
  input  wire logic        analog_dim_full,
  input  wire logic [7:0]  analog_dimming_input,
  input  wire logic        pwm_dimming_input,
  input  wire logic        pwm_dim_open,
  // Power stage and loop outputs
  output logic             gate_drive,
  output logic [7:0]       peak_ref,
  output logic [7:0]       output_current_setpoint,
  output logic             cv_boost
);

  // ==========================================
  // State
  seq_s q_ff;      // Registered state
  seq_s nxt_q;     // Next state

  // Absolute difference of two bytes
  function automatic logic [7:0] absdiff(input logic [7:0] a,
                                         input logic [7:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // ==========================================
  // Next-state logic
  always_comb begin
    logic        hard_fault;  // Fault that starts a recovery wait
    logic        hold_off;    // Condition that keeps the stage idle
    logic        leb_done;    // Main blanking over
    logic        pulse_end;   // Gate turns off this cycle
    logic [15:0] prod;        // Scratch product
    logic [16:0] rsh;         // Shifted remainder
    logic [7:0]  sp;          // Setpoint before CV clamp
    logic [2:0]  target;      // Wanted valley
    logic [2:0]  cause;       // Fault cause code
    logic [25:0] uvp_next;    // Next aux-low count
    logic        uvp_trip;    // Aux low too long
    logic        short_trip;  // Winding short confirmed
    nxt_q      = q_ff;
    hard_fault = 1'b0;
    cause      = 3'h0;
    prod       = 16'h0000;
    rsh        = 17'h00000;
    sp         = 8'h00;
    target     = 3'h0;
    uvp_next   = 26'h0;
    uvp_trip   = 1'b0;
    short_trip = 1'b0;
    hold_off   = 1'b0;
    leb_done   = 1'b0;
    pulse_end  = 1'b0;

    // Register writes
    // Only the control offset is writable; others are ignored
    if (wr && addr == `CTRL_OFS) begin
      nxt_q.ctrl = wdata[1:0];
    end

    // PWM dim low timer
    // Open or high input clears the timer at once
    if (pwm_dim_open || pwm_dimming_input) begin
      nxt_q.low_cnt  = 26'h0;
      nxt_q.pwm_dimming_input_dis = 1'b0;
    end else if (q_ff.low_cnt >= PWM_DIMMING_INPUT_LOW_CYCLES) begin
      nxt_q.pwm_dimming_input_dis = 1'b1;
    end else begin
      nxt_q.low_cnt = q_ff.low_cnt + 26'h1;
    end

    // PWM duty counters, restart on each rising edge
    nxt_q.pwm_dimming_input_prev = pwm_dimming_input;
    if (pwm_dimming_input && !q_ff.pwm_dimming_input_prev) begin
      nxt_q.rem     = {1'b0, q_ff.hi_cnt};
      nxt_q.dvs     = q_ff.per_cnt;
      nxt_q.step    = `DIV_STEPS;
      nxt_q.quo     = 8'h00;
      nxt_q.hi_cnt  = 16'h0001;
      nxt_q.per_cnt = 16'h0001;
    end else begin
      if (q_ff.per_cnt != 16'hffff) begin
        nxt_q.per_cnt = q_ff.per_cnt + 16'h1;
      end
      if (pwm_dimming_input && q_ff.hi_cnt != 16'hffff) begin
        nxt_q.hi_cnt = q_ff.hi_cnt + 16'h1;
      end
    end

    // Restoring divider: duty = high * 256 / period
    if (q_ff.step != 4'h0) begin
      rsh = {q_ff.rem[15:0], 1'b0};
      if (rsh >= {1'b0, q_ff.dvs}) begin
        nxt_q.rem = rsh - {1'b0, q_ff.dvs};
        nxt_q.quo = {q_ff.quo[6:0], 1'b1};
      end else begin
        nxt_q.rem = rsh;
        nxt_q.quo = {q_ff.quo[6:0], 1'b0};
      end
      nxt_q.step = q_ff.step - 4'h1;
      if (q_ff.step == 4'h1) begin
        nxt_q.duty = nxt_q.quo;
      end
    end

    // Setpoint selection
    sp = analog_dim_full ? `FULL_SP : analog_dimming_input;
    if (!pwm_dim_open && pwm_dimming_input &&
        q_ff.per_cnt == 16'hffff) begin
      // Dimming signal removed while high: run at full
      prod = {sp, 8'h00};
    end else if (!pwm_dim_open && q_ff.duty < `DUTY_FULL) begin
      prod = sp * q_ff.duty;
    end else begin
      prod = {sp, 8'h00};
    end
    nxt_q.setpoint = prod[15:8];
    if (cv_active && cv_level < prod[15:8]) begin
      nxt_q.setpoint = cv_level;
    end

    // Peak reference shaped by line, gain trimmed each half line
    prod = q_ff.gain * line_sample;
    nxt_q.peak_ref = (prod[15:14] != 2'h0) ? 8'hff : prod[13:6];
    if (half_line) begin
      if (q_ff.ref_acc > q_ff.setpoint * q_ff.acc_n) begin
        if (q_ff.gain != 8'h01) begin
          nxt_q.gain = q_ff.gain - 8'h1;
        end
      end else if (q_ff.gain != 8'hff) begin
        nxt_q.gain = q_ff.gain + 8'h1;
      end
      nxt_q.ref_acc = 24'h0;
      nxt_q.acc_n   = 16'h0000;
    end else if (q_ff.acc_n != 16'hffff) begin
      nxt_q.ref_acc = q_ff.ref_acc + {16'h0000, q_ff.peak_ref};
      nxt_q.acc_n   = q_ff.acc_n + 16'h1;
    end

    // Valley lock, moved only on a large setpoint or line change
    target = 3'h4 - {1'b0, q_ff.setpoint[7:6]};
    if (absdiff(q_ff.setpoint, q_ff.lock_sp) > `VALLEY_HYST ||
        absdiff(line_level, q_ff.lock_line) > `VALLEY_HYST) begin
      nxt_q.valley_sel = target;
      nxt_q.lock_sp    = q_ff.setpoint;
      nxt_q.lock_line  = line_level;
    end

    // CV loop boost threshold chosen by control bit
    nxt_q.boost = q_ff.ctrl[`CTRL_B85_BIT] ? vout_below_85
                                           : vout_below_80;

    // Aux-low timer runs only while switching
    if (q_ff.state == ST_RUN && aux_short_low) begin
      uvp_next = q_ff.uvp_cnt + 26'h1;
    end
    // Counter clears on trip; a low that lasts past the wait counts again in run and trips again
    uvp_trip      = (uvp_next >= UVP_CYCLES);
    nxt_q.uvp_cnt = uvp_trip ? 26'h0 : uvp_next;

    // Gate pulse: blanking, limits and winding short sampling
    leb_done  = (q_ff.on_cnt >= LEB_CYCLES);
    pulse_end = q_ff.gate && ((leb_done && (cs_peak || cs_ref_trip)) ||
                q_ff.on_cnt >= MAX_ON_CYCLES);
    if (q_ff.gate && !leb_done && q_ff.on_cnt >= BCS_CYCLES &&
        cs_stop) begin
      nxt_q.short_hit = 1'b1;
    end
    if (pulse_end) begin
      if (q_ff.short_hit) begin
        nxt_q.short_run = q_ff.short_run + 3'h1;
      end else begin
        nxt_q.short_run = 3'h0;
      end
      short_trip = q_ff.short_hit &&
                   (q_ff.short_run + 3'h1 >= `WSHORT_PULSES);
    end

    // Fault sources; OVPs stay armed in any regulation mode
    if (vcc_ovp) begin
      hard_fault = 1'b1;
      cause      = 3'h1;
    end
    if (aux_fast_ovp) begin
      hard_fault = 1'b1;
      cause      = 3'h2;
    end
    if (uvp_trip) begin
      hard_fault = 1'b1;
      cause      = 3'h3;
    end
    if (short_trip) begin
      hard_fault = 1'b1;
      cause      = 3'h4;
    end
    hold_off = !line_good ||
               over_temp ||
               !analog_dim_enable ||
               q_ff.pwm_dimming_input_dis;

    // Sequencer
    case (q_ff.state)
      // Idle: go to wait on a fault, else leave when no hold remains
      ST_OFF: begin
        nxt_q.gate = 1'b0;
        if (hard_fault) begin
          nxt_q.state    = ST_WAIT;
          nxt_q.wait_cnt = 26'h0;
          nxt_q.cause    = cause;
        end else if (!hold_off) begin
          nxt_q.state = ST_RUN;
        end
      end
      // Switching: faults first, then holds, then pulse timing
      ST_RUN: begin
        if (hard_fault) begin
          nxt_q.state    = ST_WAIT;
          nxt_q.gate     = 1'b0;
          nxt_q.wait_cnt = 26'h0;
          nxt_q.cause    = cause;
        end else if (hold_off) begin
          nxt_q.state = ST_OFF;
          nxt_q.gate  = 1'b0;
        end else if (pulse_end) begin
          nxt_q.gate       = 1'b0;
          nxt_q.valley_cnt = 3'h0;
        end else if (!q_ff.gate && valley_pulse && !aux_slow_ovp) begin
          // Slow OVP skips pulses in any regulation mode
          if (q_ff.valley_cnt + 3'h1 >= q_ff.valley_sel) begin
            nxt_q.gate      = 1'b1;
            nxt_q.on_cnt    = 8'h00;
            nxt_q.short_hit = 1'b0;
          end else begin
            nxt_q.valley_cnt = q_ff.valley_cnt + 3'h1;
          end
        end
        if (q_ff.gate && q_ff.on_cnt != 8'hff) begin
          nxt_q.on_cnt = q_ff.on_cnt + 8'h1;
        end
      end
      // Recovery wait: gate held low, timer restarts on refault
      ST_WAIT: begin
        nxt_q.gate      = 1'b0;
        nxt_q.short_run = 3'h0;
        if (hard_fault) begin
          nxt_q.wait_cnt = 26'h0;
          nxt_q.cause    = cause;
        end else if (q_ff.wait_cnt >= RECOVERY_CYCLES - 26'h1) begin
          nxt_q.state = ST_OFF;
        end else begin
          nxt_q.wait_cnt = q_ff.wait_cnt + 26'h1;
        end
      end
      // Illegal code: fall back to idle with the gate off
      default: begin
        nxt_q.state = ST_OFF;
        nxt_q.gate  = 1'b0;
      end
    endcase

    // Register reads, data one cycle later
    // Read data is zero outside the cycle after a read
    nxt_q.rdata = 32'h0;
    if (rd) begin
      case (addr)
        `CTRL_OFS: nxt_q.rdata = {30'h0, q_ff.ctrl};
        `STAT_OFS: nxt_q.rdata = {23'h0, q_ff.pwm_dimming_input_dis, q_ff.short_run,
                                  q_ff.cause, q_ff.state};
        `SETP_OFS: nxt_q.rdata = {8'h00, q_ff.duty, q_ff.peak_ref,
                                  q_ff.setpoint};
        default:   nxt_q.rdata = 32'h0;
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Clear all, then set the nonzero reset values
      q_ff            <= '0;
      q_ff.state      <= ST_OFF;
      q_ff.ctrl       <= `CTRL_RST;
      q_ff.gain       <= `GAIN_RST;
      q_ff.duty       <= `FULL_SP;
      q_ff.setpoint   <= `FULL_SP;
      q_ff.valley_sel <= 3'h1;
      q_ff.pwm_dimming_input_prev  <= 1'b1;
    end else begin
      // Take the whole next state at once
      q_ff <= nxt_q;
    end
  end

  // ==========================================
  // Outputs, all straight from flip-flops
  assign rdata                   = q_ff.rdata;
  assign gate_drive              = q_ff.gate;
  assign peak_ref                = q_ff.peak_ref;
  assign output_current_setpoint = q_ff.setpoint;
  assign cv_boost                = q_ff.boost;

endmodule : led_driver_protection_sequencer

// >>> verilog/led_seq_pkg.sv
// Purpose: Types for the LED driver protection sequencer.
// Assumes: Constants come from led_seq_regs.svh.
// Notes:   Whole block state is one packed struct.
package led_seq_pkg;

  // ==========================================
  // Sequencer states, Gray along off-run-wait
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_RUN  = 2'h1,
    ST_WAIT = 2'h3
  } seq_state_e;

  // ==========================================
  // Complete register state
  typedef struct packed {
    seq_state_e  state;      // Sequencer state
    logic [25:0] wait_cnt;   // Recovery timer
    logic [25:0] uvp_cnt;    // Aux-low timer
    logic [25:0] low_cnt;    // PWM dim low timer
    logic        pwm_dimming_input_dis;   // PWM dim disable
    logic        gate;       // Gate drive
    logic [7:0]  on_cnt;     // Cycles since gate on
    logic        short_hit;  // Short seen this pulse
    logic [2:0]  short_run;  // Consecutive short pulses
    logic        pwm_dimming_input_prev;  // PWM dim last level
    logic [15:0] hi_cnt;     // PWM high duration
    logic [15:0] per_cnt;    // PWM period
    logic [16:0] rem;        // Divider remainder
    logic [15:0] dvs;        // Divider divisor
    logic [3:0]  step;       // Divider steps left
    logic [7:0]  quo;        // Divider quotient
    logic [7:0]  duty;       // Measured duty
    logic [7:0]  setpoint;   // Output current setpoint
    logic [7:0]  gain;       // Peak reference gain
    logic [7:0]  peak_ref;   // Peak current reference
    logic [23:0] ref_acc;    // Reference sum over half line
    logic [15:0] acc_n;      // Samples in sum
    logic [2:0]  valley_sel; // Locked valley
    logic [7:0]  lock_sp;    // Setpoint at lock
    logic [7:0]  lock_line;  // Line level at lock
    logic [2:0]  valley_cnt; // Valleys seen this cycle
    logic        boost;      // CV loop boost
    logic [1:0]  ctrl;       // Control register
    logic [2:0]  cause;      // Last fault cause
    logic [31:0] rdata;      // Read data
  } seq_s;

endpackage : led_seq_pkg

// >>> verilog/led_seq_regs.svh
// Purpose: Constants for the LED driver protection sequencer.
// Assumes: 10 MHz clock; comparator flags arrive synchronous to it.
// Notes:   Register offsets, bit positions, timings and thresholds.
`ifndef LED_SEQ_REGS_SVH
`define LED_SEQ_REGS_SVH

// ==========================================
// Register map
`define CTRL_OFS      8'h00
`define STAT_OFS      8'h04
`define SETP_OFS      8'h08
`define CTRL_SSR_BIT  0
`define CTRL_B85_BIT  1
`define CTRL_RST      2'h0

// ==========================================
// Timing
`define CLK_HZ        10000000
`define RECOVERY_S    4
`define UVP_MS        90
`define PWM_DIMMING_INPUT_LOW_MS   25
`define RECOVERY_CYC  (`RECOVERY_S * `CLK_HZ)
`define UVP_CYC       (`UVP_MS * (`CLK_HZ / 1000))
`define PWM_DIMMING_INPUT_LOW_CYC  (`PWM_DIMMING_INPUT_LOW_MS * (`CLK_HZ / 1000))

// ==========================================
// Thresholds and counts
`define WSHORT_PULSES 3'h4
`define FULL_SP       8'hff
`define DUTY_FULL     8'hf3
`define VALLEY_HYST   8'h10
`define DIV_STEPS     4'h8
`define GAIN_RST      8'h80

`endif
